//--- shared/flash_cmd_consts.svh
// register offsets, field positions, reset values and keys of the flash command block
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_KEY        8'h04
`define OFS_OPT_KEY    8'h08
`define OFS_STATUS     8'h0C
`define OFS_CTRL       8'h10
`define OFS_ADDR       8'h14
`define OFS_OBCS       8'h1C
`define OFS_WRP        8'h20

// ----------------------------------------
// command control fields
// ----------------------------------------
`define CTRL_PROGRAM   0
`define CTRL_PAGE      1
`define CTRL_FULL      2
`define CTRL_OPT_PROG  4
`define CTRL_OPT_WIPE  5
`define CTRL_LAUNCH    6
`define CTRL_LOCK      7
`define CTRL_PERMIT    9
`define CTRL_FAULT_IE  10
`define CTRL_DONE_IE   12
`define CTRL_RELOAD    13
`define CTRL_RESET     32'h0000_0080
`define CTRL_STORE     32'h0000_1637

// ----------------------------------------
// status fields
// ----------------------------------------
`define STS_BUSY       0
`define STS_PFAULT     2
`define STS_GFAULT     4
`define STS_DONE       5

// ----------------------------------------
// option status fields
// ----------------------------------------
`define OBCS_ERR       0
`define OBCS_LVL_LO    1
`define OBCS_WDOG      8
`define OBCS_STOP      9
`define OBCS_STDBY     10
`define OBCS_BOOT1     12
`define OBCS_VDDA      13
`define OBCS_PARITY    14
`define OBCS_D0_LO     16
`define OBCS_D1_LO     24

// ----------------------------------------
// unlock keys, values arbitrary
// ----------------------------------------
`define KEY_FIRST      32'h1357_2468
`define KEY_SECOND     32'h8642_7531

`endif

//--- shared/flash_cmd_pkg.sv
// types of the flash command block
package flash_cmd_pkg;

   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_ISSUE = 2'b01,
      SEQ_WAIT  = 2'b11
   } seq_state_t;

   typedef enum logic [2:0] {
      OP_NONE      = 3'h0,
      OP_PROGRAM   = 3'h1,
      OP_PAGE_WIPE = 3'h2,
      OP_FULL_WIPE = 3'h3,
      OP_OPT_PROG  = 3'h4,
      OP_OPT_WIPE  = 3'h5
   } flash_op_t;

   typedef struct packed {
      flash_op_t   op;
      logic [31:0] addr;
   } flash_cmd_t;

   typedef struct packed {
      logic        done;
      logic        prog_fault;
      logic        guard_fault;
      logic        addr_valid;
      logic [31:0] addr;
   } flash_rsp_t;

   // byte 0 read guard, 1 user, 2 data low, 3 data high, 4..7 sector mask
   typedef struct packed {
      logic [7:0][7:0] val;
      logic [7:0][7:0] inv;
   } opt_image_t;

   typedef struct packed {
      seq_state_t  seq;
      flash_op_t   op;
      logic [31:0] ctrl;
      logic [31:0] addr;
      logic        busy;
      logic        pfault;
      logic        gfault;
      logic        done;
      logic        key_stage;
      logic [31:0] obcs;
      logic [31:0] wrp;
      logic        ack;
      logic [31:0] rdata;
      logic        reload;
      logic        sysrst;
      logic        boot;
   } regs_t;

endpackage

//--- hw/flash_command_control.sv
// command, lock and option status logic of the embedded flash controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.svh"
module flash_command_control
   import flash_cmd_pkg::*;
#(
   parameter logic [7:0] RDP_OPEN_CODE = 8'h5A,
   parameter logic [7:0] RDP_FULL_CODE = 8'hC3
) (
   // clock and reset
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_rst,
   // wishbone slave
   input  wire logic                     i_wb_cyc,
   input  wire logic                     i_wb_stb,
   input  wire logic                     i_wb_we,
   input  wire logic [31:0]              i_wb_adr,
   input  wire logic [31:0]              i_wb_dat,
   input  wire logic [3:0]               i_wb_sel,
   output logic      [31:0]              o_wb_dat,
   output logic                          o_wb_ack,
   // flash array
   output flash_cmd_pkg::flash_cmd_t     o_flash_cmd,
   output logic                          o_flash_cmd_valid,
   input  wire flash_cmd_pkg::flash_rsp_t i_flash_rsp,
   // option byte store
   output logic                          o_opt_load_req,
   input  wire logic                     i_opt_valid,
   input  wire flash_cmd_pkg::opt_image_t i_opt_image,
   // system
   output logic                          o_sys_reset_req,
   output logic                          o_busy,
   output logic                          o_irq
);
   import flash_cmd_pkg::*;

   localparam regs_t REGS_RESET = '{seq: SEQ_IDLE, op: OP_NONE, ctrl: `CTRL_RESET, boot: 1'b1, default: '0};

   regs_t           q;
   regs_t           d;
   logic [7:0][7:0] byte_fix;
   logic [7:0]      byte_ok;
   logic            opt_err;
   logic [1:0]      guard_lvl;
   logic [31:0]     obcs_load;
   logic            hit;
   logic            wr;
   logic            rd;
   logic            mapped;
   logic [31:0]     wmask;
   logic [31:0]     ctrl_new;
   logic            wr_ctrl;
   logic            launch_try;
   logic [4:0]      op_bits;
   flash_op_t       op_sel;
   logic            one_hot;

   // ----------------------------------------
   // option image check
   // ----------------------------------------
   for (genvar g = 0; g < 8; g++) begin : g_opt_byte
      assign byte_ok[g]  = (i_opt_image.val[g] == ~i_opt_image.inv[g]);
      assign byte_fix[g] = byte_ok[g] ? i_opt_image.val[g] : 8'hFF;
   end

   assign opt_err   = ~&byte_ok;
   assign guard_lvl = (byte_fix[0] == RDP_OPEN_CODE) ? 2'b00 :
                      (byte_fix[0] == RDP_FULL_CODE) ? 2'b10 : 2'b01;

   always_comb begin
      obcs_load                               = '0;
      obcs_load[`OBCS_ERR]                    = opt_err;
      obcs_load[`OBCS_LVL_LO +: 2]            = guard_lvl;
      obcs_load[`OBCS_WDOG]                   = byte_fix[1][0];
      obcs_load[`OBCS_STOP]                   = byte_fix[1][1];
      obcs_load[`OBCS_STDBY]                  = byte_fix[1][2];
      obcs_load[`OBCS_BOOT1]                  = byte_fix[1][3];
      obcs_load[`OBCS_VDDA]                   = byte_fix[1][4];
      obcs_load[`OBCS_PARITY]                 = byte_fix[1][5];
      obcs_load[`OBCS_D0_LO +: 8]             = byte_fix[2];
      obcs_load[`OBCS_D1_LO +: 8]             = byte_fix[3];
   end

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign hit    = i_wb_cyc & i_wb_stb & ~q.ack;
   assign wr     = hit & i_wb_we;
   assign rd     = hit & ~i_wb_we;
   assign mapped = (i_wb_adr[31:8] == 24'h00_0000);
   assign wmask  = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
   assign wr_ctrl = wr & mapped & (i_wb_adr[7:0] == `OFS_CTRL);

   // ----------------------------------------
   // operation decode
   // ----------------------------------------
   always_comb begin
      ctrl_new = (q.ctrl & ~wmask) | (i_wb_dat & wmask);
      op_bits  = {ctrl_new[`CTRL_OPT_WIPE], ctrl_new[`CTRL_OPT_PROG], ctrl_new[`CTRL_FULL],
                  ctrl_new[`CTRL_PAGE], ctrl_new[`CTRL_PROGRAM]};
      one_hot  = (op_bits != 5'h00) && ((op_bits & (op_bits - 5'h01)) == 5'h00);
      case (op_bits)
         5'h01:   op_sel = OP_PROGRAM;
         5'h02:   op_sel = OP_PAGE_WIPE;
         5'h04:   op_sel = OP_FULL_WIPE;
         5'h08:   op_sel = OP_OPT_PROG;
         5'h10:   op_sel = OP_OPT_WIPE;
         default: op_sel = OP_NONE;
      endcase
      launch_try = wr_ctrl & ~q.ctrl[`CTRL_LOCK] & ctrl_new[`CTRL_LAUNCH] & (q.seq == SEQ_IDLE);
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      d        = q;
      d.ack    = hit;
      d.reload = q.boot;
      d.sysrst = 1'b0;
      d.boot   = 1'b0;
      if (rd) begin
         d.rdata = 32'h0000_0000;
         if (mapped) begin
            case (i_wb_adr[7:0])
               `OFS_STATUS: begin
                  d.rdata[`STS_BUSY]   = q.busy;
                  d.rdata[`STS_PFAULT] = q.pfault;
                  d.rdata[`STS_GFAULT] = q.gfault;
                  d.rdata[`STS_DONE]   = q.done;
               end
               `OFS_CTRL: d.rdata = q.ctrl;
               `OFS_ADDR: d.rdata = q.addr;
               `OFS_OBCS: d.rdata = q.obcs;
               `OFS_WRP:  d.rdata = q.wrp;
               default:   d.rdata = 32'h0000_0000;
            endcase
         end
      end
      // software writes
      if (wr && mapped) begin
         case (i_wb_adr[7:0])
            `OFS_KEY: begin
               if (i_wb_sel == 4'hF && !q.key_stage && i_wb_dat == `KEY_FIRST) begin
                  d.key_stage = 1'b1;
               end else if (i_wb_sel == 4'hF && q.key_stage && i_wb_dat == `KEY_SECOND) begin
                  d.key_stage           = 1'b0;
                  d.ctrl[`CTRL_LOCK]    = 1'b0;
               end else begin
                  d.key_stage = 1'b0;
               end
            end
            `OFS_STATUS: begin
               if (wmask[`STS_PFAULT] && i_wb_dat[`STS_PFAULT]) d.pfault = 1'b0;
               if (wmask[`STS_GFAULT] && i_wb_dat[`STS_GFAULT]) d.gfault = 1'b0;
               if (wmask[`STS_DONE] && i_wb_dat[`STS_DONE]) d.done = 1'b0;
            end
            `OFS_CTRL: begin
               if (!q.ctrl[`CTRL_LOCK]) begin
                  d.ctrl                = (ctrl_new & `CTRL_STORE) | `CTRL_RESET & ctrl_new;
                  d.ctrl[`CTRL_LOCK]    = ctrl_new[`CTRL_LOCK];
                  d.ctrl[`CTRL_LAUNCH]  = q.ctrl[`CTRL_LAUNCH];
                  d.ctrl[`CTRL_RELOAD]  = 1'b0;
                  if (ctrl_new[`CTRL_RELOAD]) begin
                     d.reload = 1'b1;
                     d.sysrst = 1'b1;
                  end
               end
            end
            `OFS_ADDR: begin
               if (!q.ctrl[`CTRL_LOCK] && !q.busy) d.addr = (q.addr & ~wmask) | (i_wb_dat & wmask);
            end
            default: d.key_stage = q.key_stage;
         endcase
      end
      // sequencer, hardware sets win over software clears
      case (q.seq)
         SEQ_IDLE: begin
            if (launch_try && one_hot) begin
               if (op_sel == OP_OPT_PROG && !ctrl_new[`CTRL_PERMIT]) begin
                  d.gfault = 1'b1;
               end else begin
                  d.ctrl[`CTRL_LAUNCH] = 1'b1;
                  d.busy               = 1'b1;
                  d.op                 = op_sel;
                  d.seq                = SEQ_ISSUE;
               end
            end
         end
         SEQ_ISSUE: d.seq = SEQ_WAIT;
         SEQ_WAIT: begin
            if (i_flash_rsp.done) begin
               d.seq                = SEQ_IDLE;
               d.busy               = 1'b0;
               d.ctrl[`CTRL_LAUNCH] = 1'b0;
               d.done               = 1'b1;
               d.op                 = OP_NONE;
               if (i_flash_rsp.prog_fault) d.pfault = 1'b1;
               if (i_flash_rsp.guard_fault) d.gfault = 1'b1;
            end
         end
         default: d.seq = SEQ_IDLE;
      endcase
      if (q.busy && i_flash_rsp.addr_valid) d.addr = i_flash_rsp.addr;
      if (i_opt_valid) begin
         d.obcs = obcs_load;
         d.wrp  = {byte_fix[7], byte_fix[6], byte_fix[5], byte_fix[4]};
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         q <= REGS_RESET;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_wb_dat          = q.rdata;
   assign o_wb_ack          = q.ack;
   assign o_flash_cmd_valid = (q.seq == SEQ_ISSUE);
   assign o_flash_cmd       = '{op: q.op, addr: q.addr};
   assign o_opt_load_req    = q.reload;
   assign o_sys_reset_req   = q.sysrst;
   assign o_busy            = q.busy;
   assign o_irq             = (q.ctrl[`CTRL_FAULT_IE] & (q.pfault | q.gfault))
                            | (q.ctrl[`CTRL_DONE_IE] & q.done);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   sequence s_launch;
      (q.seq == SEQ_IDLE) && (d.seq == SEQ_ISSUE);
   endsequence

   sequence s_finish;
      (q.seq == SEQ_WAIT) && i_flash_rsp.done;
   endsequence

   property p_reset_value;
      $past(i_rst) |-> (q.ctrl == `CTRL_RESET) && !q.busy;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("control not at reset value");

   property p_lock_holds;
      wr_ctrl && q.ctrl[`CTRL_LOCK] && (q.seq == SEQ_IDLE) |=> $stable(q.ctrl);
   endproperty
   a_lock_holds: assert property (p_lock_holds) else $error("locked control changed");

   property p_busy_span;
      s_launch |=> q.busy && o_flash_cmd_valid && q.ctrl[`CTRL_LAUNCH] ##1 q.busy && !o_flash_cmd_valid;
   endproperty
   a_busy_span: assert property (p_busy_span) else $error("busy or command missing after launch");

   property p_finish;
      s_finish |=> !q.busy && !q.ctrl[`CTRL_LAUNCH] && q.done;
   endproperty
   a_finish: assert property (p_finish) else $error("finish did not clear start or set done");

   property p_key_zero;
      rd && mapped && (i_wb_adr[7:0] == `OFS_KEY) |=> o_wb_ack && (o_wb_dat == 32'h0000_0000);
   endproperty
   a_key_zero: assert property (p_key_zero) else $error("key register read not zero");

   property p_permit;
      launch_try && (op_sel == OP_OPT_PROG) && !ctrl_new[`CTRL_PERMIT] |=> !q.busy && q.gfault;
   endproperty
   a_permit: assert property (p_permit) else $error("option program ran without permit");

   property p_reload;
      wr_ctrl && !q.ctrl[`CTRL_LOCK] && ctrl_new[`CTRL_RELOAD] |=> o_sys_reset_req && o_opt_load_req;
   endproperty
   a_reload: assert property (p_reload) else $error("reload request missing");

   property p_addr_track;
      q.busy && i_flash_rsp.addr_valid |=> q.addr == $past(i_flash_rsp.addr);
   endproperty
   a_addr_track: assert property (p_addr_track) else $error("address not tracked");

   property p_opt_error;
      i_opt_valid && !byte_ok[0] |=> q.obcs[`OBCS_ERR] && (q.obcs[`OBCS_LVL_LO +: 2] != 2'b00);
   endproperty
   a_opt_error: assert property (p_opt_error) else $error("option error not flagged");

   property p_done_irq;
      q.done && q.ctrl[`CTRL_DONE_IE] |-> o_irq;
   endproperty
   a_done_irq: assert property (p_done_irq) else $error("done interrupt missing");

   property p_fault_irq;
      (q.pfault || q.gfault) && q.ctrl[`CTRL_FAULT_IE] |-> o_irq;
   endproperty
   a_fault_irq: assert property (p_fault_irq) else $error("fault interrupt missing");

   property p_op_decode;
      s_launch |=> ((q.op == OP_PROGRAM) == $past(ctrl_new[`CTRL_PROGRAM]))
                && ((q.op == OP_PAGE_WIPE) == $past(ctrl_new[`CTRL_PAGE]))
                && ((q.op == OP_FULL_WIPE) == $past(ctrl_new[`CTRL_FULL]))
                && ((q.op == OP_OPT_PROG) == $past(ctrl_new[`CTRL_OPT_PROG]))
                && ((q.op == OP_OPT_WIPE) == $past(ctrl_new[`CTRL_OPT_WIPE]));
   endproperty
   a_op_decode: assert property (p_op_decode) else $error("operation code does not match select bit");

   property p_start_sw;
      $rose(q.ctrl[`CTRL_LAUNCH]) |-> $past(launch_try);
   endproperty
   a_start_sw: assert property (p_start_sw) else $error("start bit set without software launch");

   property p_lock_set_only;
      q.ctrl[`CTRL_LOCK] && !(wr && mapped && (i_wb_adr[7:0] == `OFS_KEY) && q.key_stage) |=> q.ctrl[`CTRL_LOCK];
   endproperty
   a_lock_set_only: assert property (p_lock_set_only) else $error("lock cleared without key");

   property p_unlock;
      wr && mapped && (i_wb_adr[7:0] == `OFS_KEY) && (i_wb_sel == 4'hF) && q.key_stage
      && (i_wb_dat == `KEY_SECOND) |=> !q.ctrl[`CTRL_LOCK];
   endproperty
   a_unlock: assert property (p_unlock) else $error("key sequence did not unlock");

   property p_permit_ok;
      launch_try && (op_sel == OP_OPT_PROG) && ctrl_new[`CTRL_PERMIT] |=> q.busy;
   endproperty
   a_permit_ok: assert property (p_permit_ok) else $error("permitted option program did not start");

   property p_busy_hold;
      q.busy && !((q.seq == SEQ_WAIT) && i_flash_rsp.done) |=> q.busy;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped before finish");

   property p_done_hold;
      q.done && !(wr && mapped && (i_wb_adr[7:0] == `OFS_STATUS) && wmask[`STS_DONE] && i_wb_dat[`STS_DONE])
      |=> q.done;
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("done flag lost without clear");

   property p_opt_forced;
      i_opt_valid && !byte_ok[3] |=> q.obcs[`OBCS_ERR] && (q.obcs[`OBCS_D1_LO +: 8] == 8'hFF);
   endproperty
   a_opt_forced: assert property (p_opt_forced) else $error("bad option byte not forced");

   property p_level_open;
      i_opt_valid && byte_ok[0] && (i_opt_image.val[0] == RDP_OPEN_CODE) |=> q.obcs[`OBCS_LVL_LO +: 2] == 2'b00;
   endproperty
   a_level_open: assert property (p_level_open) else $error("open guard code not level 0");

   property p_option_bits;
      i_opt_valid && byte_ok[1] |=> q.obcs[`OBCS_WDOG +: 3] == $past(i_opt_image.val[1][2:0]);
   endproperty
   a_option_bits: assert property (p_option_bits) else $error("watchdog or reset choice wrong");

   property p_wrp;
      i_opt_valid && (&byte_ok[7:4]) |=> q.wrp == $past(i_opt_image.val[7:4]);
   endproperty
   a_wrp: assert property (p_wrp) else $error("sector guard mask wrong");

endmodule // flash_command_control
`default_nettype wire

//--- tb/flash_array_model.sv
// behavioural flash array and option byte store beside the command block
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
   import flash_cmd_pkg::*;
#(
   parameter int DELAY = 6
) (
   // clock and reset
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_rst,
   // flash array
   input  wire flash_cmd_pkg::flash_cmd_t  i_cmd,
   input  wire logic                       i_cmd_valid,
   input  wire logic                       i_pfault,
   output flash_cmd_pkg::flash_rsp_t       o_rsp,
   // option byte store
   input  wire logic                       i_load_req,
   input  wire flash_cmd_pkg::opt_image_t  i_image,
   output logic                            o_opt_valid,
   output flash_cmd_pkg::opt_image_t       o_image
);
   int          cnt;
   logic        act;
   logic [31:0] adr;
   // image lines show the inverse outside the valid pulse
   assign o_image = o_opt_valid ? i_image : ~i_image;
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         act         <= 1'b0;
         cnt         <= 0;
         o_opt_valid <= 1'b0;
         o_rsp       <= '0;
      end else begin
         o_opt_valid       <= i_load_req;
         o_rsp.done        <= 1'b0;
         o_rsp.prog_fault  <= ~o_rsp.prog_fault;
         o_rsp.guard_fault <= ~o_rsp.guard_fault;
         o_rsp.addr_valid  <= act;
         // address in use runs ahead of the command address
         o_rsp.addr        <= act ? adr + 32'h0000_0100 : ~o_rsp.addr;
         if (i_cmd_valid) begin
            act <= 1'b1;
            cnt <= DELAY;
            adr <= i_cmd.addr;
         end else if (act && cnt > 1) begin
            cnt <= cnt - 1;
         end else if (act) begin
            act               <= 1'b0;
            o_rsp.done        <= 1'b1;
            o_rsp.prog_fault  <= i_pfault;
            o_rsp.guard_fault <= 1'b0;
         end
      end
   end
endmodule // flash_array_model
`default_nettype wire

//--- tb/flash_command_control_tb.sv
// self-checking bench of the flash command block
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module flash_command_control_tb;
   import flash_cmd_pkg::*;
   typedef struct packed { logic [7:0] g; logic [7:0] b1; logic [31:0] obcs; } row_t;
   logic ref_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, pfault = 0;
   logic [31:0] adr = '0, dat = '0, rd, q, want, last_adr;
   logic [3:0]  sel = 4'h0;
   logic        ack, cmd_valid, load_req, opt_valid, sysrst, busy, irq;
   flash_cmd_t  cmd;
   flash_rsp_t  rsp;
   opt_image_t  img, image;
   flash_op_t   last_op;
   int          error_cnt = 0, num_checks = 0, ncmd = 0, nrst = 0;
   row_t        rows [3] = '{'{8'h5A, 8'h01, 32'hFFA5_0101}, '{8'hC3, 8'h02, 32'hFFA5_0205},
                             '{8'h11, 8'h3C, 32'hFFA5_7403}};
   int          bitpos [5] = '{0, 1, 2, 4, 5};
   flash_op_t   code [5] = '{OP_PROGRAM, OP_PAGE_WIPE, OP_FULL_WIPE, OP_OPT_PROG, OP_OPT_WIPE};
   initial forever #2.5 ref_clk = ~ref_clk;
   flash_command_control flash_command_control_inst (.i_ref_clk(ref_clk), .i_rst(rst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(rd),
      .o_wb_ack(ack), .o_flash_cmd(cmd), .o_flash_cmd_valid(cmd_valid), .i_flash_rsp(rsp),
      .o_opt_load_req(load_req), .i_opt_valid(opt_valid), .i_opt_image(image),
      .o_sys_reset_req(sysrst), .o_busy(busy), .o_irq(irq));
   flash_array_model flash_array_model_inst (.i_ref_clk(ref_clk), .i_rst(rst), .i_cmd(cmd),
      .i_cmd_valid(cmd_valid), .i_pfault(pfault), .o_rsp(rsp), .i_load_req(load_req),
      .i_image(img), .o_opt_valid(opt_valid), .o_image(image));
   always @(posedge ref_clk) begin
      if (cmd_valid === 1'b1) begin
         last_op <= cmd.op;
         last_adr <= cmd.addr;
         ncmd    <= ncmd + 1;
      end
      if (sysrst === 1'b1) nrst <= nrst + 1;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {24'h0, a}; dat <= d; sel <= 4'hF;
      do begin @(posedge ref_clk); n++; end while (ack !== 1'b1 && n < 50);
      q = rd;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      `CHK(n < 50, 1'b1)
   endtask
   task automatic unlock();
      wb(1, `OFS_KEY, `KEY_FIRST);
      wb(1, `OFS_KEY, `KEY_SECOND);
   endtask
   task automatic set_image(input row_t r);
      img.val = {32'h7856_3412, 8'h3C, 8'hA5, r.b1, r.g};
      img.inv = ~img.val;
      img.inv[3] = img.val[3];
      if (r.g == 8'h11) img.inv[0] = img.val[0];
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin @(posedge ref_clk); n++; end while (busy !== 1'b0 && n < 100);
      `CHK(n < 100, 1'b1)
   endtask
   initial begin
      #100_000;
      error_cnt++;
      conclude();
   end
   initial begin
      set_image(rows[0]);
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      // ----------------------------------------
      // option image rows, boot load then reloads
      // ----------------------------------------
      for (int i = 0; i < 3; i++) begin
         if (i > 0) begin
            set_image(rows[i]);
            unlock();
            wb(1, `OFS_CTRL, 32'h0000_2000);
            repeat (6) @(posedge ref_clk);
            `CHK(nrst, i)
         end
         wb(0, `OFS_OBCS, 0); `CHK(q, rows[i].obcs)
         wb(0, `OFS_WRP, 0); `CHK(q, 32'h7856_3412)
      end
      $display("test option rows done");
      // ----------------------------------------
      // reset in mid run, key and unmapped reads
      // ----------------------------------------
      rst <= 1'b1;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      wb(0, `OFS_CTRL, 0); `CHK(q, 32'h0000_0080)
      wb(0, `OFS_KEY, 0); `CHK(q, 32'h0000_0000)
      wb(0, 8'hF0, 0); `CHK(q, 32'h0000_0000)
      wb(1, `OFS_CTRL, 32'h0000_0001);
      wb(1, `OFS_KEY, `KEY_SECOND);
      wb(0, `OFS_CTRL, 0); `CHK(q, 32'h0000_0080)
      unlock();
      wb(0, `OFS_CTRL, 0); `CHK(q, 32'h0000_0000)
      $display("test reset and lock done");
      // ----------------------------------------
      // every operation, start bit and address
      // ----------------------------------------
      for (int i = 0; i < 5; i++) begin
         want = (32'h1 << bitpos[i]) | ((bitpos[i] == 4) ? 32'h0000_0200 : 32'h0);
         wb(1, `OFS_ADDR, 32'h0800_0400 + 32'(i * 4));
         wb(1, `OFS_CTRL, want | 32'h0000_0040);
         wb(0, `OFS_CTRL, 0); `CHK(q, want | 32'h0000_0040)
         @(negedge ref_clk); `CHK(busy, 1'b1)
         wait_idle();
         `CHK(last_op, code[i])
         `CHK(last_adr, 32'h0800_0400 + 32'(i * 4))
         wb(0, `OFS_CTRL, 0); `CHK(q, want)
         wb(0, `OFS_STATUS, 0); `CHK(q, 32'h0000_0020)
         wb(0, `OFS_ADDR, 0); `CHK(q, 32'h0800_0500 + 32'(i * 4))
         wb(1, `OFS_STATUS, 32'h0000_0034);
      end
      `CHK(ncmd, 5)
      $display("test operations done");
      // ----------------------------------------
      // refused option program, fault and done interrupts
      // ----------------------------------------
      wb(1, `OFS_CTRL, 32'h0000_0450);
      repeat (3) @(posedge ref_clk);
      `CHK(ncmd, 5)
      wb(0, `OFS_STATUS, 0); `CHK(q, 32'h0000_0010)
      @(negedge ref_clk); `CHK(irq, 1'b1)
      wb(1, `OFS_STATUS, 32'h0000_0034);
      @(negedge ref_clk); `CHK(irq, 1'b0)
      pfault <= 1'b1;
      wb(1, `OFS_CTRL, 32'h0000_1441);
      wait_idle();
      pfault <= 1'b0;
      wb(0, `OFS_STATUS, 0); `CHK(q, 32'h0000_0024)
      @(negedge ref_clk); `CHK(irq, 1'b1)
      wb(1, `OFS_CTRL, 32'h0000_1000);
      wb(1, `OFS_STATUS, 32'h0000_0004);
      @(negedge ref_clk); `CHK(irq, 1'b1)
      wb(1, `OFS_STATUS, 32'h0000_0020);
      @(negedge ref_clk); `CHK(irq, 1'b0)
      $display("test interrupts done");
      // ----------------------------------------
      // relock, then writes are ignored
      // ----------------------------------------
      wb(1, `OFS_CTRL, 32'h0000_0080);
      wb(1, `OFS_CTRL, 32'h0000_0001);
      wb(0, `OFS_CTRL, 0); `CHK(q, 32'h0000_0080)
      $display("test relock done");
      conclude();
   end
endmodule // flash_command_control_tb
`default_nettype wire
